// >>> pmdb_cfg.svh
`ifndef PMDB_CFG_SVH
`define PMDB_CFG_SVH

// Byte offsets of the disable registers on the register bus
`define PMDB_OFF_M1         8'h00
`define PMDB_OFF_M2         8'h04
`define PMDB_OFF_M3         8'h08
`define PMDB_OFF_M4         8'h0C
`define PMDB_OFF_M6         8'h10
`define PMDB_OFF_M7         8'h14
`define PMDB_OFF_M8         8'h18
`define PMDB_OFF_S1         8'h1C

// Number of registers and index field of the byte address
`define PMDB_NUM_REGS       8
`define PMDB_IDX_LSB        2
`define PMDB_IDX_MSB        4
`define PMDB_PAGE_LSB       5

// Implemented-bit masks
`define PMDB_MASK_M1        16'h0EFF
`define PMDB_MASK_M2        16'h00FF
`define PMDB_MASK_M3        16'h0082
`define PMDB_MASK_M4        16'h0008
`define PMDB_MASK_M6        16'h3F00
`define PMDB_MASK_M7        16'h0108
`define PMDB_MASK_M8        16'h183E
`define PMDB_MASK_S1        16'h0EA9

// Power-on value of every disable register
`define PMDB_RESET_VAL      16'h0000

// AXI responses
`define PMDB_RESP_OKAY      2'h0
`define PMDB_RESP_SLVERR    2'h2

`endif

// >>> pmdb_pkg.sv
package pmdb_pkg;

    typedef logic [15:0] pmdb_word_t;
    typedef logic [2:0]  pmdb_idx_t;
    typedef logic [7:0]  pmdb_addr_t;

endpackage

// >>> pmdb_bank.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pmdb_cfg.svh"

// Overview of operation
// - Bits 11, 10 and 9 of the first master register switch off the timer, encoder and PWM.
// - Bits 7 to 0 of the first master register switch off I2C1, UART2, UART1, SPI2, SPI1, CAN2, CAN1 and the ADC.
// - Bits 7 to 0 of the second master register switch off capture/compare units 8 to 1; its high byte is absent.
// - The third and eighth registers exist only in the master register space.
// - The fourth register holds only bit 3, which switches off the reference clock output.
// - Bits 13 to 8 of the sixth master register switch off DMA channels 5 to 0; all else is absent.
// - The eighth register holds SENT bits 12 and 11, logic cell bits 5 to 2 and current source bit 1.
// - Every absent bit reads as zero.
// - Every present bit is read/write and clears to zero at reset; all enables are low during reset, so peripherals start on one cycle after release.
// - The slave first register keeps timer, encoder, PWM, I2C1, UART1, SPI1 and ADC bits only.
// - A set bit stops every clock to its peripheral.
// - A peripheral turns off or on one cycle after its bit changes.
// - A switched-off peripheral ignores writes to its own registers, since its clock is held off.
module pmdb_bank
(
    input  wire logic        aclk,           // System clock
    input  wire logic        aresetn,        // Synchronous reset, active low
    input  wire logic        ce,             // Clock enable, freezes all state when low
    input  wire logic [7:0]  s_axi_awaddr,   // Write address
    input  wire logic [2:0]  s_axi_awprot,   // Write protection, unused
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [7:0]  s_axi_araddr,   // Read address
    input  wire logic [2:0]  s_axi_arprot,   // Read protection, unused
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    output logic [15:0]      m1_clk_en,      // Master group 1 clock enables
    output logic [15:0]      m2_clk_en,      // Master group 2 clock enables
    output logic [15:0]      m3_clk_en,      // Master group 3 clock enables
    output logic [15:0]      m4_clk_en,      // Master group 4 clock enables
    output logic [15:0]      m6_clk_en,      // Master group 6 clock enables
    output logic [15:0]      m7_clk_en,      // Master group 7 clock enables
    output logic [15:0]      m8_clk_en,      // Master group 8 clock enables
    output logic [15:0]      s1_clk_en       // Slave group 1 clock enables
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    function automatic pmdb_pkg::pmdb_word_t mask_of(input pmdb_pkg::pmdb_idx_t idx);
        pmdb_pkg::pmdb_word_t m;
        m = 16'h0000;
        unique case (idx)
            3'h0: m = `PMDB_MASK_M1;
            3'h1: m = `PMDB_MASK_M2;
            3'h2: m = `PMDB_MASK_M3;
            3'h3: m = `PMDB_MASK_M4;
            3'h4: m = `PMDB_MASK_M6;
            3'h5: m = `PMDB_MASK_M7;
            3'h6: m = `PMDB_MASK_M8;
            3'h7: m = `PMDB_MASK_S1;
        endcase
        return m;
    endfunction

    function automatic logic addr_hit(input pmdb_pkg::pmdb_addr_t a);
        return (a[7:`PMDB_PAGE_LSB] == 3'h0);
    endfunction

    function automatic pmdb_pkg::pmdb_idx_t addr_idx(input pmdb_pkg::pmdb_addr_t a);
        return a[`PMDB_IDX_MSB:`PMDB_IDX_LSB];
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    pmdb_pkg::pmdb_word_t bank_q [`PMDB_NUM_REGS];
    pmdb_pkg::pmdb_word_t bank_d [`PMDB_NUM_REGS];
    pmdb_pkg::pmdb_word_t en_q   [`PMDB_NUM_REGS];
    pmdb_pkg::pmdb_word_t en_d   [`PMDB_NUM_REGS];

    logic                 awready_q;
    logic                 awready_d;
    logic                 wready_q;
    logic                 wready_d;
    logic                 aw_hold_q;
    logic                 aw_hold_d;
    logic                 w_hold_q;
    logic                 w_hold_d;
    pmdb_pkg::pmdb_addr_t waddr_q;
    pmdb_pkg::pmdb_addr_t waddr_d;
    logic [15:0]          wdata_q;
    logic [15:0]          wdata_d;
    logic [1:0]           wstrb_q;
    logic [1:0]           wstrb_d;
    logic                 bvalid_q;
    logic                 bvalid_d;
    logic [1:0]           bresp_q;
    logic [1:0]           bresp_d;
    logic                 arready_q;
    logic                 arready_d;
    logic                 rvalid_q;
    logic                 rvalid_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic [1:0]           rresp_q;
    logic [1:0]           rresp_d;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------

    always_comb
    begin
        pmdb_pkg::pmdb_idx_t  widx;
        pmdb_pkg::pmdb_word_t wm;
        widx = addr_idx(waddr_q);
        wm   = mask_of(widx);
        for (int i = 0; i < `PMDB_NUM_REGS; i++)
        begin
            bank_d[i] = bank_q[i];
        end
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_hold_d = 1'b1;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata[15:0];
            wstrb_d  = s_axi_wstrb[1:0];
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        // Commit once both halves are held and no response is pending
        if (aw_hold_q && w_hold_q && !bvalid_q)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            if (addr_hit(waddr_q))
            begin
                bresp_d = `PMDB_RESP_OKAY;
                if (wstrb_q[0])
                begin
                    bank_d[widx][7:0] = wdata_q[7:0] & wm[7:0];
                end
                if (wstrb_q[1])
                begin
                    bank_d[widx][15:8] = wdata_q[15:8] & wm[15:8];
                end
            end
            else
            begin
                bresp_d = `PMDB_RESP_SLVERR;
            end
        end
        awready_d = !aw_hold_d;
        wready_d  = !w_hold_d;
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------

    always_comb
    begin
        pmdb_pkg::pmdb_idx_t ridx;
        ridx      = addr_idx(s_axi_araddr);
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        arready_d = arready_q;
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        else if (!rvalid_q && !arready_q)
        begin
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d  = 1'b1;
            arready_d = 1'b0;
            if (addr_hit(s_axi_araddr))
            begin
                rdata_d = {16'h0000, bank_q[ridx] & mask_of(ridx)};
                rresp_d = `PMDB_RESP_OKAY;
            end
            else
            begin
                rdata_d = 32'h0000_0000;
                rresp_d = `PMDB_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------

    // One cycle after a bit changes, the enable follows it
    always_comb
    begin
        for (int i = 0; i < `PMDB_NUM_REGS; i++)
        begin
            en_d[i] = ~bank_q[i] & mask_of(pmdb_pkg::pmdb_idx_t'(i));
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < `PMDB_NUM_REGS; i++)
            begin
                bank_q[i] <= `PMDB_RESET_VAL;
                en_q[i]   <= 16'h0000;
            end
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `PMDB_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `PMDB_RESP_OKAY;
        end
        else if (ce)
        begin
            for (int i = 0; i < `PMDB_NUM_REGS; i++)
            begin
                bank_q[i] <= bank_d[i];
                en_q[i]   <= en_d[i];
            end
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Low enable holds the peripheral clock off, so its own registers ignore writes
    assign m1_clk_en = en_q[0];
    assign m2_clk_en = en_q[1];
    assign m3_clk_en = en_q[2];
    assign m4_clk_en = en_q[3];
    assign m6_clk_en = en_q[4];
    assign m7_clk_en = en_q[5];
    assign m8_clk_en = en_q[6];
    assign s1_clk_en = en_q[7];

endmodule

// >>> pmdb_bank_chk.sv
`timescale 1ns/1ps
`include "pmdb_cfg.svh"

module pmdb_bank_chk
(
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset
    input wire logic        ce,            // Enable
    input wire logic        s_axi_awvalid, // AW
    input wire logic        s_axi_awready, // AW
    input wire logic        s_axi_wvalid,  // W
    input wire logic        s_axi_wready,  // W
    input wire logic [1:0]  s_axi_bresp,   // B
    input wire logic        s_axi_bvalid,  // B
    input wire logic        s_axi_bready,  // B
    input wire logic [7:0]  s_axi_araddr,  // AR
    input wire logic        s_axi_arvalid, // AR
    input wire logic        s_axi_arready, // AR
    input wire logic [31:0] s_axi_rdata,   // R
    input wire logic [1:0]  s_axi_rresp,   // R
    input wire logic        s_axi_rvalid,  // R
    input wire logic        s_axi_rready,  // R
    input wire logic [15:0] m1_clk_en,     // Group 1
    input wire logic [15:0] m8_clk_en,     // Group 8
    input wire logic [15:0] s1_clk_en      // Slave 1
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_absent_low:
        assert property ((m1_clk_en & ~`PMDB_MASK_M1) == 16'h0000
            && (s1_clk_en & ~`PMDB_MASK_S1) == 16'h0000)
        else $error("enable on absent bit");
    a_reset_on:
        assert property ($rose(aresetn) |-> ##2 m8_clk_en == `PMDB_MASK_M8
            && m1_clk_en == `PMDB_MASK_M1)
        else $error("enables not set after reset");
    a_enable_delay:
        assert property ($changed({m1_clk_en, m8_clk_en, s1_clk_en})
            |-> $past(s_axi_bvalid) || !$past(aresetn, 3))
        else $error("enable moved without write");
    a_write_resp:
        assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_mapped:
        assert property (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] == 3'h0
            |=> s_axi_rvalid && s_axi_rresp == `PMDB_RESP_OKAY && s_axi_rdata[31:16] == 16'h0000)
        else $error("bad mapped read");
    a_read_unmapped:
        assert property (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
            |=> s_axi_rvalid && s_axi_rresp == `PMDB_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad unmapped read");
endmodule

bind pmdb_bank pmdb_bank_chk pmdb_bank_chk_inst (.*);

// >>> pmdb_bank_bench.sv
`timescale 1ns/1ps
`include "pmdb_cfg.svh"

module pmdb_bank_bench;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] m1_clk_en, m2_clk_en, m3_clk_en, m4_clk_en;
    logic [15:0] m6_clk_en, m7_clk_en, m8_clk_en, s1_clk_en;
    logic [15:0] en [8], mdl [8], msk [8];
    int          num_errors, checks;

    pmdb_bank pmdb_bank_inst (.*);

    assign en = '{m1_clk_en, m2_clk_en, m3_clk_en, m4_clk_en,
                  m6_clk_en, m7_clk_en, m8_clk_en, s1_clk_en};

    always #50 aclk = ~aclk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 60)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t bus timeout", $time);
            give_verdict();
        end
    endtask

    // ----------
    // Bus cycles
    // ----------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (ce && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (ce && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!(ce && s_axi_bvalid && s_axi_bready) && n < 60);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (ce && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!(ce && s_axi_rvalid && s_axi_rready) && n < 60);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic wreg(input int i, input logic [31:0] d, input logic [3:0] s);
        wr(8'(i * 4), d, s, `PMDB_RESP_OKAY);
        if (s[0])
            mdl[i][7:0] = d[7:0] & msk[i][7:0];
        if (s[1])
            mdl[i][15:8] = d[15:8] & msk[i][15:8];
    endtask

    task automatic vall;
        @(posedge aclk);
        for (int i = 0; i < 8; i++)
        begin
            chk(32'(en[i]), 32'(~mdl[i] & msk[i]));
            rd(8'(i * 4), 32'(mdl[i]), `PMDB_RESP_OKAY);
        end
    endtask

    // ---------
    // Scenarios
    // ---------
    task automatic t_reset;
        mdl = '{default: 16'h0000};
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Enables leave their reset value only at the first edge after release
        @(posedge aclk);
        vall();
        $display("test reset done");
    endtask

    task automatic t_fields;
        logic [31:0] v [3] = '{32'hFFFF_FFFF, 32'h0000_5AA5, 32'h0000_0000};
        foreach (v[k])
        begin
            for (int i = 0; i < 8; i++)
                wreg(i, v[k], 4'hF);
            vall();
        end
        $display("test fields done");
    endtask

    task automatic t_strobe;
        wreg(0, 32'h0000_FFFF, 4'h3);
        wreg(6, 32'h0000_FFFF, 4'h3);
        wreg(0, 32'h0000_0000, 4'h1);
        wreg(6, 32'h0000_0000, 4'h2);
        wreg(7, 32'hFFFF_FFFF, 4'hC);
        vall();
        $display("test strobe done");
    endtask

    task automatic t_unmapped;
        wr(8'h20, 32'hFFFF_FFFF, 4'hF, `PMDB_RESP_SLVERR);
        wr(8'hFC, 32'hFFFF_FFFF, 4'hF, `PMDB_RESP_SLVERR);
        rd(8'h20, 32'h0, `PMDB_RESP_SLVERR);
        rd(8'hE4, 32'h0, `PMDB_RESP_SLVERR);
        wr(8'h0B, 32'h0000_FFFF, 4'hF, `PMDB_RESP_OKAY);
        mdl[2] = msk[2];
        vall();
        $display("test unmapped done");
    endtask

    task automatic t_ce;
        ce <= 1'b0;
        fork
            wreg(4, 32'h0000_2A00, 4'hF);
            begin
                repeat (6) @(posedge aclk);
                ce <= 1'b1;
            end
        join
        vall();
        $display("test enable done");
    endtask

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        num_errors = 0;
        checks = 0;
        msk = '{`PMDB_MASK_M1, `PMDB_MASK_M2, `PMDB_MASK_M3, `PMDB_MASK_M4,
                `PMDB_MASK_M6, `PMDB_MASK_M7, `PMDB_MASK_M8, `PMDB_MASK_S1};
        t_reset();
        t_fields();
        t_strobe();
        t_unmapped();
        t_ce();
        t_reset();
        give_verdict();
    end
endmodule
